// >>> hdl/arl_result_limit.v
`timescale 1ns/1ps
`include "arl_consts.vh"
// How it works
// - Each cycle accumulates a sum and tracks minimum and maximum samples.
// - Sum is 16 bits, read as upper and lower byte registers.
// - Min and max are 10 bits, split into 2 upper and 8 lower.
// - Sample code is input over full scale times 1023.
// - In repeating limit mode, stored maximum above high limit flags a high fault and interrupts.
// - In repeating limit mode, stored minimum below low limit flags a low fault and interrupts.
// - Low limit zero and high limit all ones never fault.
// - Count field 00 with repeat compares each single sample to limits.
// - Repeating limit mode restarts until a fault or enable cleared.
// - Count field 01-11 with repeat forms a 12-bit average per cycle.
// - Average is sum shifted right 2, 3 or 4 for 16, 32, 64.
// - In averaging mode the average, not samples, meets the limits.
// - Status is read-only; reading it clears the summary interrupt flag.
// - Status bits: 7 done, 6 error, 5 high, 4 low, 1-0 pins.
module arl_result_limit (
   input wire ref_clk_i,
   input wire rst_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   input wire [7:0] reg_addr_i,
   input wire [7:0] reg_wdata_i,
   output reg [7:0] reg_rdata_o,
   input wire converter_enable_i,
   input wire repeat_i,
   input wire [1:0] sample_count_i,
   input wire cycle_start_i,
   input wire sample_valid_i,
   input wire [9:0] sample_i,
   input wire converter_error_i,
   input wire trigger_pin_a_i,
   input wire trigger_pin_b_i,
   output wire converter_summary_irq_o,
   output wire restart_o,
   output wire busy_o
);
   // ---------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------
   reg [1:0] pin_meta_reg;
   reg [1:0] pin_sync_reg;
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         pin_meta_reg <= 2'h0;
         pin_sync_reg <= 2'h0;
      end else begin
         pin_meta_reg <= {trigger_pin_b_i, trigger_pin_a_i};
         pin_sync_reg <= pin_meta_reg;
      end
   end

   // ---------------------------------------------
   // Cycle sequencer
   // ---------------------------------------------
   localparam ST_IDLE = 3'h1;
   localparam ST_RUN = 3'h2;
   localparam ST_EVAL = 3'h4;
   reg [2:0] state_reg;
   reg [2:0] state_next;
   reg [6:0] cnt_reg;
   reg [6:0] target;
   reg [1:0] mode_reg;
   wire start = (state_reg == ST_IDLE) & converter_enable_i & cycle_start_i;
   wire last_sample;
   wire any_fault;
   wire single_mode = (mode_reg == `ARL_MODE_SINGLE);

   // ---------------------------------------------
   // Mode latch
   // ---------------------------------------------
   // Held for the whole cycle so a mid-cycle change cannot move the end point
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         mode_reg <= `ARL_MODE_SINGLE;
      end else if (start) begin
         mode_reg <= sample_count_i;
      end
   end

   always @* begin
      case (mode_reg)
         `ARL_MODE_16: target = `ARL_COUNT_16;
         `ARL_MODE_32: target = `ARL_COUNT_32;
         `ARL_MODE_64: target = `ARL_COUNT_64;
         default: target = `ARL_COUNT_1;
      endcase
   end

   assign last_sample = sample_valid_i & (cnt_reg + 7'h01 == target);

   always @* begin
      case (state_reg)
         ST_IDLE: state_next = start ? ST_RUN : ST_IDLE;
         ST_RUN: begin
            if (!converter_enable_i) begin
               state_next = ST_IDLE;
            end else if (last_sample) begin
               state_next = ST_EVAL;
            end else begin
               state_next = ST_RUN;
            end
         end
         ST_EVAL: state_next = ST_IDLE;
         default: state_next = ST_IDLE;
      endcase
   end

   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         state_reg <= ST_IDLE;
         cnt_reg <= 7'h00;
      end else begin
         state_reg <= state_next;
         if (start) begin
            cnt_reg <= 7'h00;
         end else if (state_reg == ST_RUN && sample_valid_i) begin
            cnt_reg <= cnt_reg + 7'h01;
         end
      end
   end

   assign busy_o = (state_reg != ST_IDLE);
   // Repeat until a fault or enable dropped
   assign restart_o = (state_reg == ST_EVAL) & repeat_i & converter_enable_i & ~any_fault;

   // ---------------------------------------------
   // Arithmetic unit
   // ---------------------------------------------
   wire [15:0] sum_acc;
   wire [9:0] min_val;
   wire [9:0] max_val;
   arl_alu #(
      .SW(10),
      .AW(16)
   ) u_alu (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .start_i(start),
      .sample_valid_i(sample_valid_i & (state_reg == ST_RUN)),
      .sample_i(sample_i),
      .sum_o(sum_acc),
      .min_o(min_val),
      .max_o(max_val)
   );

   // ---------------------------------------------
   // Limit registers
   // ---------------------------------------------
   reg [11:0] upper_threshold_reg;
   reg [11:0] lower_threshold_reg;
   // ---------------------------------------------
   // Write decode
   // ---------------------------------------------
   // Only the four limit bytes are writable; everything else ignores writes
   wire wr_hi_up = reg_wr_i & (reg_addr_i == `ARL_HILIM_UP_ADDR);
   wire wr_hi_lo = reg_wr_i & (reg_addr_i == `ARL_HILIM_LO_ADDR);
   wire wr_lo_up = reg_wr_i & (reg_addr_i == `ARL_LOLIM_UP_ADDR);
   wire wr_lo_lo = reg_wr_i & (reg_addr_i == `ARL_LOLIM_LO_ADDR);

   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         upper_threshold_reg <= `ARL_HILIMIT_RST;
      end else begin
         if (wr_hi_up) begin
            upper_threshold_reg[11:8] <= reg_wdata_i[3:0];
         end
         if (wr_hi_lo) begin
            upper_threshold_reg[7:0] <= reg_wdata_i;
         end
      end
   end

   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         lower_threshold_reg <= `ARL_LIMIT_RST;
      end else begin
         if (wr_lo_up) begin
            lower_threshold_reg[11:8] <= reg_wdata_i[3:0];
         end
         if (wr_lo_lo) begin
            lower_threshold_reg[7:0] <= reg_wdata_i;
         end
      end
   end

   // ---------------------------------------------
   // Average and compare
   // ---------------------------------------------
   reg [2:0] shift;
   always @* begin
      case (mode_reg)
         `ARL_MODE_16: shift = `ARL_SHIFT_16;
         `ARL_MODE_32: shift = `ARL_SHIFT_32;
         default: shift = `ARL_SHIFT_64;
      endcase
   end
   wire [15:0] shifted = sum_acc >> shift;
   wire [11:0] average = shifted[11:0];
   // Single mode compares the 10-bit sample extremes directly
   wire [11:0] hi_value = single_mode ? {2'h0, max_val} : average;
   wire [11:0] lo_value = single_mode ? {2'h0, min_val} : average;
   wire hi_trip;
   wire lo_trip;

   arl_limit_cmp #(.W(12)) u_hi_cmp (
      .value_i(hi_value),
      .limit_i(upper_threshold_reg),
      .check_high_i(1'b1),
      .fault_o(hi_trip)
   );
   arl_limit_cmp #(.W(12)) u_lo_cmp (
      .value_i(lo_value),
      .limit_i(lower_threshold_reg),
      .check_high_i(1'b0),
      .fault_o(lo_trip)
   );
   // Only meaningful in repeating limit mode
   wire check = (state_reg == ST_EVAL) & repeat_i;
   assign any_fault = check & (hi_trip | lo_trip);

   // ---------------------------------------------
   // Status and summary interrupt
   // ---------------------------------------------
   reg done_reg;
   reg err_reg;
   reg hi_flt_reg;
   reg lo_flt_reg;
   reg [1:0] pin_cap_reg;
   reg irq_reg;
   wire status_rd = reg_rd_i & (reg_addr_i == `ARL_STATUS_ADDR);
   wire eoc = (state_reg == ST_EVAL);
   wire irq_set = eoc | converter_error_i;

   // ---------------------------------------------
   // Done, error and pin capture
   // ---------------------------------------------
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         done_reg <= 1'b0;
         pin_cap_reg <= 2'h0;
      end else if (start) begin
         done_reg <= 1'b0;
      end else if (eoc) begin
         done_reg <= 1'b1;
         pin_cap_reg <= pin_sync_reg;
      end
   end

   // Error set wins over the clear of a new start
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         err_reg <= 1'b0;
      end else if (converter_error_i) begin
         err_reg <= 1'b1;
      end else if (start) begin
         err_reg <= 1'b0;
      end
   end

   // ---------------------------------------------
   // Limit fault flags
   // ---------------------------------------------
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         hi_flt_reg <= 1'b0;
      end else if (check & hi_trip) begin
         hi_flt_reg <= 1'b1;
      end else if (start) begin
         hi_flt_reg <= 1'b0;
      end
   end

   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         lo_flt_reg <= 1'b0;
      end else if (check & lo_trip) begin
         lo_flt_reg <= 1'b1;
      end else if (start) begin
         lo_flt_reg <= 1'b0;
      end
   end

   // ---------------------------------------------
   // Summary interrupt
   // ---------------------------------------------
   // Set wins over the read clear
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         irq_reg <= 1'b0;
      end else if (irq_set) begin
         irq_reg <= 1'b1;
      end else if (status_rd) begin
         irq_reg <= 1'b0;
      end
   end
   assign converter_summary_irq_o = irq_reg;

   // ---------------------------------------------
   // Read path
   // ---------------------------------------------
   reg [7:0] status_word;
   always @* begin
      status_word = 8'h00;
      status_word[`ARL_ST_DONE_BIT] = done_reg;
      status_word[`ARL_ST_ERR_BIT] = err_reg;
      status_word[`ARL_ST_HI_BIT] = hi_flt_reg;
      status_word[`ARL_ST_LO_BIT] = lo_flt_reg;
      status_word[`ARL_ST_PINB_BIT] = pin_cap_reg[1];
      status_word[`ARL_ST_PINA_BIT] = pin_cap_reg[0];
   end

   // ---------------------------------------------
   // Register read mux
   // ---------------------------------------------
   // Unmapped addresses read as zero
   reg [7:0] read_mux;
   always @* begin
      read_mux = 8'h00;
      case (reg_addr_i)
         `ARL_HILIM_UP_ADDR: read_mux = {4'h0, upper_threshold_reg[11:8]};
         `ARL_HILIM_LO_ADDR: read_mux = upper_threshold_reg[7:0];
         `ARL_LOLIM_UP_ADDR: read_mux = {4'h0, lower_threshold_reg[11:8]};
         `ARL_LOLIM_LO_ADDR: read_mux = lower_threshold_reg[7:0];
         `ARL_SUM_UP_ADDR: read_mux = sum_acc[15:8];
         `ARL_SUM_LO_ADDR: read_mux = sum_acc[7:0];
         `ARL_PEAK_UP_ADDR: read_mux = {6'h00, max_val[9:8]};
         `ARL_PEAK_LO_ADDR: read_mux = max_val[7:0];
         `ARL_TROUGH_UP_ADDR: read_mux = {6'h00, min_val[9:8]};
         `ARL_TROUGH_LO_ADDR: read_mux = min_val[7:0];
         `ARL_STATUS_ADDR: read_mux = status_word;
         default: read_mux = 8'h00;
      endcase
   end

   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_rd_i) begin
         reg_rdata_o <= read_mux;
      end
   end
endmodule

// >>> hdl/arl_consts.vh
`ifndef ARL_CONSTS_VH
`define ARL_CONSTS_VH
// ---------------------------------------------
// Register offsets
// ---------------------------------------------
`define ARL_HILIM_UP_ADDR 8'h63
`define ARL_HILIM_LO_ADDR 8'h64
`define ARL_LOLIM_UP_ADDR 8'h65
`define ARL_LOLIM_LO_ADDR 8'h66
`define ARL_SUM_UP_ADDR 8'h94
`define ARL_SUM_LO_ADDR 8'h95
`define ARL_PEAK_UP_ADDR 8'h96
`define ARL_PEAK_LO_ADDR 8'h97
`define ARL_TROUGH_UP_ADDR 8'h98
`define ARL_TROUGH_LO_ADDR 8'h99
`define ARL_STATUS_ADDR 8'h9A
// ---------------------------------------------
// Field positions and values
// ---------------------------------------------
`define ARL_ST_DONE_BIT 7
`define ARL_ST_ERR_BIT 6
`define ARL_ST_HI_BIT 5
`define ARL_ST_LO_BIT 4
`define ARL_ST_PINB_BIT 1
`define ARL_ST_PINA_BIT 0
`define ARL_LIMIT_RST 12'h000
`define ARL_HILIMIT_RST 12'hFFF
`define ARL_SAMPLE_FULL 10'h3FF
`define ARL_MODE_SINGLE 2'h0
`define ARL_MODE_16 2'h1
`define ARL_MODE_32 2'h2
`define ARL_MODE_64 2'h3
`define ARL_SHIFT_16 3'h2
`define ARL_SHIFT_32 3'h3
`define ARL_SHIFT_64 3'h4
`define ARL_COUNT_1 7'h01
`define ARL_COUNT_16 7'h10
`define ARL_COUNT_32 7'h20
`define ARL_COUNT_64 7'h40
`endif

// >>> hdl/arl_limit_cmp.v
`timescale 1ns/1ps
// ---------------------------------------------
// One 12-bit limit comparator
// ---------------------------------------------
module arl_limit_cmp #(
   parameter W = 12
) (
   input wire [W-1:0] value_i,
   input wire [W-1:0] limit_i,
   input wire check_high_i,
   output wire fault_o
);
   // Strict compare: all-ones high and zero low never trip
   assign fault_o = check_high_i ? (value_i > limit_i) : (value_i < limit_i);
endmodule

// >>> hdl/arl_alu.v
`timescale 1ns/1ps
`include "arl_consts.vh"
// ---------------------------------------------
// Sum, min and max over one conversion cycle
// ---------------------------------------------
module arl_alu #(
   parameter SW = 10,
   parameter AW = 16
) (
   input wire ref_clk_i,
   input wire rst_i,
   input wire start_i,
   input wire sample_valid_i,
   input wire [SW-1:0] sample_i,
   output wire [AW-1:0] sum_o,
   output wire [SW-1:0] min_o,
   output wire [SW-1:0] max_o
);
   reg [AW-1:0] sum_reg;
   reg [SW-1:0] min_reg;
   reg [SW-1:0] max_reg;
   assign sum_o = sum_reg;
   assign min_o = min_reg;
   assign max_o = max_reg;
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         sum_reg <= {AW{1'b0}};
         min_reg <= {SW{1'b1}};
         max_reg <= {SW{1'b0}};
      end else if (start_i) begin
         sum_reg <= {AW{1'b0}};
         min_reg <= {SW{1'b1}};
         max_reg <= {SW{1'b0}};
      end else if (sample_valid_i) begin
         sum_reg <= sum_reg + {{(AW-SW){1'b0}}, sample_i};
         if (sample_i < min_reg) begin
            min_reg <= sample_i;
         end
         if (sample_i > max_reg) begin
            max_reg <= sample_i;
         end
      end
   end
endmodule

// >>> test/arl_result_limit_chk.sv
`timescale 1ns/1ps
// ----
// Port checks
// ----
module arl_result_limit_chk (
   input wire ref_clk_i,
   input wire rst_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   input wire [7:0] reg_addr_i,
   input wire [7:0] reg_wdata_i,
   input wire [7:0] reg_rdata_o,
   input wire converter_enable_i,
   input wire repeat_i,
   input wire [1:0] sample_count_i,
   input wire cycle_start_i,
   input wire sample_valid_i,
   input wire [9:0] sample_i,
   input wire converter_error_i,
   input wire trigger_pin_a_i,
   input wire trigger_pin_b_i,
   input wire converter_summary_irq_o,
   input wire restart_o,
   input wire busy_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   wire [7:0] a = reg_addr_i;
   wire mapped = (a >= 8'h63 && a <= 8'h66) || (a >= 8'h94 && a <= 8'h9A);
   property p_unmap; reg_rd_i && !mapped |=> reg_rdata_o == 8'h00; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   property p_st_rsv; reg_rd_i && a == 8'h9A |=> reg_rdata_o[3:2] == 2'h0; endproperty
   a_st_rsv: assert property (p_st_rsv) else $error("status spare bits set");
   property p_pk_up; reg_rd_i && (a == 8'h96 || a == 8'h98) |=> reg_rdata_o[7:2] == 6'h00; endproperty
   a_pk_up: assert property (p_pk_up) else $error("peak upper spare bits set");
   property p_lim_up; reg_rd_i && (a == 8'h63 || a == 8'h65) |=> reg_rdata_o[7:4] == 4'h0; endproperty
   a_lim_up: assert property (p_lim_up) else $error("limit upper spare bits set");
   property p_irq_clr;
      reg_rd_i && a == 8'h9A && !busy_o && !converter_error_i && !$past(converter_error_i)
      |=> !converter_summary_irq_o;
   endproperty
   a_irq_clr: assert property (p_irq_clr) else $error("irq kept after status read");
   property p_start; !busy_o && cycle_start_i && converter_enable_i |=> busy_o; endproperty
   a_start: assert property (p_start) else $error("start not taken");
   property p_rst;
      restart_o |-> (busy_o && repeat_i && converter_enable_i) ##1 (!busy_o && converter_summary_irq_o);
   endproperty
   a_rst: assert property (p_rst) else $error("restart out of place");
   property p_done;
      $fell(busy_o) && converter_enable_i && $past(converter_enable_i) |-> converter_summary_irq_o;
   endproperty
   a_done: assert property (p_done) else $error("no irq at cycle end");
endmodule
bind arl_result_limit arl_result_limit_chk arl_result_limit_chk_inst (.*);

// >>> test/arl_conv_model.sv
`timescale 1ns/1ps
// ----
// Converter core: one code per request, after gap cycles
// ----
module arl_conv_model (
   input wire ref_clk_i,
   input wire go_i,
   input wire [9:0] code_i,
   input wire [3:0] gap_i,
   output reg sample_valid_o = 1'b0,
   output reg [9:0] sample_o = 10'h155
);
   reg pend = 1'b0;
   reg [3:0] cnt = 4'h0;
   always @(posedge ref_clk_i) begin
      sample_valid_o <= 1'b0;
      sample_o <= ~sample_o;
      if (go_i) begin
         pend <= 1'b1;
         cnt <= gap_i;
      end else if (pend && cnt != 4'h0) begin
         cnt <= cnt - 4'h1;
      end else if (pend) begin
         pend <= 1'b0;
         sample_valid_o <= 1'b1;
         sample_o <= code_i;
      end
   end
endmodule

// >>> test/adc_result_alu_limit_check_test.sv
`timescale 1ns/1ps
module adc_result_alu_limit_check_test;
   reg ref_clk_i = 0, rst_i = 1, wr = 0, rd = 0, en = 0, rpt = 0, start = 0, err = 0, pa = 0, pb = 0, go = 0;
   reg [7:0] addr = 0, wd = 0, q, q2;
   reg [1:0] csel = 0;
   reg [9:0] code = 0;
   reg [3:0] gap = 0;
   reg [31:0] seed = 32'h3EB634BB;
   reg fh, fl;
   reg rs_seen = 0;
   wire [7:0] rdata;
   wire irq, rs, busy, sv;
   wire [9:0] smp;
   integer mismatches = 0, check_count = 0, cyc = 0, i, j, k, n, sum, mx, mn, hi, lo, ah, al;
   always #2.5 ref_clk_i = ~ref_clk_i;
   arl_result_limit arl_result_limit_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_wr_i(wr), .reg_rd_i(rd),
      .reg_addr_i(addr), .reg_wdata_i(wd), .reg_rdata_o(rdata), .converter_enable_i(en), .repeat_i(rpt),
      .sample_count_i(csel), .cycle_start_i(start), .sample_valid_i(sv), .sample_i(smp),
      .converter_error_i(err), .trigger_pin_a_i(pa), .trigger_pin_b_i(pb),
      .converter_summary_irq_o(irq), .restart_o(rs), .busy_o(busy));
   arl_conv_model arl_conv_model_inst (.ref_clk_i(ref_clk_i), .go_i(go), .code_i(code), .gap_i(gap),
      .sample_valid_o(sv), .sample_o(smp));
   function [31:0] xs(input [31:0] s);
      reg [31:0] t;
      begin
         t = s ^ (s << 13);
         t = t ^ (t >> 17);
         xs = t ^ (t << 5);
      end
   endfunction
   task chk(input [63:0] nm, input [15:0] e, input [15:0] g);
      begin
         check_count = check_count + 1;
         if (g !== e) begin
            mismatches = mismatches + 1;
            $display("[ERR] %0s exp %h got %h", nm, e, g);
         end
      end
   endtask
   task give_verdict;
      begin
         $display("checks %0d mismatches %0d", check_count, mismatches);
         if (mismatches == 0 && check_count > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask
   task acc(input w, input [7:0] a, input [7:0] d);
      begin
         @(posedge ref_clk_i);
         wr <= w;
         rd <= !w;
         addr <= a;
         wd <= d;
         @(posedge ref_clk_i);
         wr <= 1'b0;
         rd <= 1'b0;
         #1 q = rdata;
      end
   endtask
   task run(input [1:0] m, input ef, input dflt);
      begin
         n = (m == 0) ? 1 : (8 << m);
         sum = 0;
         mx = 0;
         mn = 1023;
         seed = xs(seed);
         hi = dflt ? 12'hFFF : seed[11:0] >> (m ? 0 : 2);
         lo = dflt ? 0 : seed[23:12] >> (m ? 1 : 3);
         acc(1, 8'h63, hi[11:8]);
         acc(1, 8'h64, hi[7:0]);
         acc(1, 8'h65, lo[11:8]);
         acc(1, 8'h66, lo[7:0]);
         @(posedge ref_clk_i);
         pa <= seed[24];
         pb <= seed[25];
         csel <= m;
         start <= 1'b1;
         @(posedge ref_clk_i);
         start <= 1'b0;
         for (i = 0; i < n; i = i + 1) begin
            seed = xs(seed);
            code <= seed[9:0];
            gap <= seed[13:10] & 4'h3;
            go <= 1'b1;
            @(posedge ref_clk_i);
            go <= 1'b0;
            for (k = 0; k < 20 && sv !== 1'b1; k = k + 1) @(posedge ref_clk_i);
            sum = sum + seed[9:0];
            if (seed[9:0] > mx) mx = seed[9:0];
            if (seed[9:0] < mn) mn = seed[9:0];
            err <= ef && i == 0;
         end
         err <= 1'b0;
         for (k = 0; k < 10 && busy !== 1'b0; k = k + 1) @(posedge ref_clk_i);
         acc(1, 8'h94, 8'hFF);
         ah = m ? sum >> (m + 1) : mx;
         al = m ? sum >> (m + 1) : mn;
         fh = rpt && (ah > hi);
         fl = rpt && (al < lo);
         chk("irq", 1, irq);
         acc(0, 8'h9A, 0);
         chk("status", {1'b1, ef, fh, fl, 2'b00, pb, pa}, q);
         chk("irqclr", 0, irq);
         chk("restart", rpt && !fh && !fl, rs_seen);
         acc(0, 8'h94, 0);
         q2 = q;
         acc(0, 8'h95, 0);
         chk("sum", sum, {q2, q});
         acc(0, 8'h96, 0);
         q2 = q;
         acc(0, 8'h97, 0);
         chk("max", mx, {q2, q});
         acc(0, 8'h98, 0);
         q2 = q;
         acc(0, 8'h99, 0);
         chk("min", mn, {q2, q});
      end
   endtask
   always @(posedge ref_clk_i) begin
      if (start) begin
         rs_seen <= 1'b0;
      end else if (rs) begin
         rs_seen <= 1'b1;
      end
   end
   always @(posedge ref_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         mismatches = mismatches + 1;
         give_verdict;
      end
   end
   initial begin
      repeat (20) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      en <= 1'b1;
      rpt <= 1'b1;
      acc(0, 8'h63, 0);
      chk("hiup", 8'h0F, q);
      acc(0, 8'h70, 0);
      chk("unmap", 0, q);
      run(0, 0, 1);
      for (j = 0; j < 9; j = j + 1) run(j % 4, j == 5, 0);
      @(posedge ref_clk_i);
      csel <= 2'h1;
      start <= 1'b1;
      @(posedge ref_clk_i);
      start <= 1'b0;
      @(posedge ref_clk_i);
      chk("busy", 1, busy);
      en <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
      chk("abort", 0, busy);
      chk("irqabort", 0, irq);
      en <= 1'b1;
      rpt <= 1'b0;
      acc(0, 8'h9A, 0);
      chk("stabort", 0, q[7]);
      run(2, 0, 0);
      give_verdict;
   end
endmodule
